//--- rtl/cee_pkg.sv
/*
 * constants and types for the event enable/disable command decoder.
 * assumes one 100 mhz system clock; the serial link pins arrive asynchronously.
 */
package cee_pkg;
	// ****************************************
	// command framing
	// ****************************************
	localparam logic [7:0] CEE_BCAST_W = 8'hfc;
	localparam logic [7:0] CEE_CMD_EN_BC = 8'h00;
	localparam logic [7:0] CEE_CMD_DIS_BC = 8'h01;
	localparam logic [7:0] CEE_CMD_EN_DIR = 8'h80;
	localparam logic [7:0] CEE_CMD_DIS_DIR = 8'h81;
	localparam int CEE_FLAG_POS = 0;
	localparam logic [7:0] CEE_CRC_POLY = 8'h07;
	localparam logic [7:0] CEE_CRC_INIT = 8'h00;
	localparam logic CEE_IRQ_EN_RST = 1'b0;
	localparam logic [3:0] CEE_ACK_BIT = 4'h8;
	localparam logic [3:0] CEE_LAST_DBIT = 4'h7;

	// ****************************************
	// state
	// ****************************************
	typedef enum logic [7:0] {
		CEE_IDLE = 8'h01,
		CEE_ADDR = 8'h02,
		CEE_CODE = 8'h04,
		CEE_PEC1 = 8'h08,
		CEE_WSR = 8'h10,
		CEE_DATA = 8'h20,
		CEE_PEC2 = 8'h40,
		CEE_SKIP = 8'h80
	} cee_state_t;

	typedef struct packed {
		cee_state_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] code;
		logic [7:0] data;
		logic [7:0] crc;
		logic dir;
		logic ack;
		logic oe;
		logic nack;
		logic err;
		logic idle;
		logic pend;
		logic irq_en;
	} cee_ctl_t;

	typedef struct packed {
		logic [2:0] scl;
		logic [2:0] sda;
	} cee_sync_t;
endpackage

//--- rtl/cee_ccc_event_ctl.sv
/*
 * decoder for the broadcast and direct enable-events / disable-events commands,
 * with parity, packet checksum and address-mismatch handling.
 * assumes scl and sda come straight from pins; the open-drain wire is resolved outside.
 */
// Summary of operation
// [R1] the commands are decoded only in i3c basic mode; in i2c mode the frame is skipped.
// [R2] a registered disable-events clears the pending enable, applied at the next start after stop.
// [R3] the checksum runs from start or repeat start and leaves out the 7'h7e write byte.
// [R4] after a parity error, the address byte following a repeat start is not acknowledged.
// [R5] with checksum on, a parity or checksum error also makes that address byte unacknowledged.
// [R6] a direct command whose target address is not ours is skipped without checks until sr or stop.
// [R7] the enable flag at 1 enables interrupts, at 0 nothing happens.
// [R8] the disable flag at 1 disables interrupts, at 0 nothing happens.
// [R9] stop, repeat start, and repeat start with 7'h7e are all recognised as frame boundaries.
// [R10] a registered enable-events sets the pending enable, applied at the next start after stop.
// [R11] the host places a stop between common commands and private transfers.
// [R12] a received checksum that differs from ours blocks the enable change.
module cee_ccc_event_ctl
	import cee_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_pin,
	input wire logic sda_pin,
	output logic sda_out,
	output logic sda_oe,
	input wire logic i3c_mode,
	input wire logic pec_enable,
	input wire logic [6:0] own_addr,
	output logic inband_irq_enable_bit,
	output logic irq_enable_pending,
	output logic frame_error
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ CEE_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	cee_sync_t sy_r, sy_nxt;
	always_comb begin
		sy_nxt.scl = {sy_r.scl[1:0], scl_pin};
		sy_nxt.sda = {sy_r.sda[1:0], sda_pin};
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// reset to the idle-high bus level so no false edge follows reset
			sy_r <= '1;
		end else begin
			sy_r <= sy_nxt;
		end
	end

	// stage 1 is old-stage-2, stage 2 is the delayed copy used for edges
	logic scl_s, sda_s, scl_d, sda_d;
	logic scl_rise, scl_fall, start_ev, stop_ev;
	assign scl_s = sy_r.scl[1];
	assign sda_s = sy_r.sda[1];
	assign scl_d = sy_r.scl[2];
	assign sda_d = sy_r.sda[2];
	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign start_ev = scl_s && scl_d && sda_d && !sda_s;
	assign stop_ev = scl_s && scl_d && !sda_d && sda_s;

	// ****************************************
	// command decoder
	// ****************************************
	cee_ctl_t c_r, c_nxt;
	logic [7:0] byte_in;
	logic par_bad, pec_bad, bit_ok;
	assign byte_in = {c_r.sh[6:0], sda_s};
	assign par_bad = (sda_s != ~^c_r.sh);
	assign pec_bad = (c_r.sh != c_r.crc);

	always_comb begin
		c_nxt = c_r;
		bit_ok = 1'b0;
		if (start_ev) begin
			// a start out of idle makes the registered change visible
			if (c_r.idle) begin
				c_nxt.irq_en = c_r.pend; // [R2] [R10]
				c_nxt.nack = 1'b0;
				c_nxt.dir = 1'b0;
			end else begin
				c_nxt.nack = c_r.err; // [R4] [R5] [R9]
			end
			c_nxt.st = i3c_mode ? CEE_ADDR : CEE_SKIP; // [R1]
			c_nxt.cnt = '0;
			c_nxt.crc = CEE_CRC_INIT; // [R3]
			c_nxt.err = 1'b0;
			c_nxt.idle = 1'b0;
			c_nxt.oe = 1'b0;
			c_nxt.ack = 1'b0;
		end else if (stop_ev) begin
			c_nxt.st = CEE_IDLE; // [R9]
			c_nxt.idle = 1'b1;
			c_nxt.nack = 1'b0;
			c_nxt.err = 1'b0;
			c_nxt.oe = 1'b0;
			c_nxt.ack = 1'b0;
		end else if (scl_fall) begin
			c_nxt.oe = c_r.ack && (c_r.cnt == CEE_ACK_BIT);
		end else if (scl_rise && c_r.st != CEE_IDLE) begin
			c_nxt.cnt = (c_r.cnt == CEE_ACK_BIT) ? 4'h0 : c_r.cnt + 4'h1;
			if (c_r.cnt < CEE_ACK_BIT) begin
				c_nxt.sh = byte_in;
			end
			// address acknowledge is decided as soon as the eighth bit lands
			if (c_r.cnt == CEE_LAST_DBIT && c_r.st == CEE_ADDR) begin
				c_nxt.ack = !c_r.nack && i3c_mode && ((byte_in == CEE_BCAST_W)
					|| (c_r.dir && byte_in == {own_addr, 1'b0})); // [R4] [R5]
			end
			if (c_r.cnt == CEE_ACK_BIT) begin
				c_nxt.ack = 1'b0;
				bit_ok = !par_bad && !c_r.err;
				case (c_r.st)
				CEE_ADDR: begin
					c_nxt.nack = 1'b0;
					if (!i3c_mode) begin
						c_nxt.st = CEE_SKIP; // [R1]
					end else if (c_r.sh == CEE_BCAST_W && !c_r.nack) begin
						c_nxt.st = CEE_CODE; // [R3] [R9]
					end else if (c_r.dir && c_r.sh == {own_addr, 1'b0} && !c_r.nack) begin
						c_nxt.crc = crc8(c_r.crc, c_r.sh);
						c_nxt.st = CEE_DATA;
					end else begin
						c_nxt.st = CEE_SKIP; // [R6]
					end
				end
				CEE_CODE: begin
					c_nxt.code = c_r.sh;
					c_nxt.crc = crc8(c_r.crc, c_r.sh);
					c_nxt.err = c_r.err || par_bad;
					if (c_r.sh == CEE_CMD_EN_BC || c_r.sh == CEE_CMD_DIS_BC) begin
						c_nxt.dir = 1'b0;
						c_nxt.st = CEE_DATA;
					end else if (c_r.sh == CEE_CMD_EN_DIR || c_r.sh == CEE_CMD_DIS_DIR) begin
						c_nxt.dir = 1'b1;
						c_nxt.st = pec_enable ? CEE_PEC1 : CEE_WSR;
					end else begin
						c_nxt.st = CEE_SKIP;
					end
				end
				CEE_PEC1: begin
					c_nxt.err = c_r.err || par_bad || pec_bad; // [R5] [R12]
					c_nxt.st = CEE_WSR;
				end
				CEE_DATA: begin
					c_nxt.data = c_r.sh;
					c_nxt.crc = crc8(c_r.crc, c_r.sh);
					c_nxt.err = c_r.err || par_bad; // [R4]
					if (pec_enable) begin
						c_nxt.st = CEE_PEC2;
					end else begin
						c_nxt.st = CEE_WSR;
						if (bit_ok && c_r.sh[CEE_FLAG_POS]) begin
							c_nxt.pend = !c_r.code[0]; // [R7] [R8] [R2] [R10]
						end
					end
				end
				CEE_PEC2: begin
					c_nxt.err = c_r.err || par_bad || pec_bad; // [R5]
					c_nxt.st = CEE_WSR;
					if (bit_ok && !pec_bad && c_r.data[CEE_FLAG_POS]) begin
						c_nxt.pend = !c_r.code[0]; // [R12] [R7] [R8]
					end
				end
				CEE_WSR, CEE_SKIP: begin
					c_nxt.st = c_r.st; // [R6] no checks while waiting for sr or stop
				end
				default: begin
					c_nxt.st = CEE_SKIP;
				end
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			c_r <= '{st: CEE_IDLE, cnt: '0, sh: '0, code: '0, data: '0, crc: CEE_CRC_INIT,
				dir: 1'b0, ack: 1'b0, oe: 1'b0, nack: 1'b0, err: 1'b0, idle: 1'b1,
				pend: CEE_IRQ_EN_RST, irq_en: CEE_IRQ_EN_RST};
		end else begin
			c_r <= c_nxt;
		end
	end

	// open-drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = c_r.oe;
	assign inband_irq_enable_bit = c_r.irq_en;
	assign irq_enable_pending = c_r.pend;
	assign frame_error = c_r.err;

	// ****************************************
	// checks
	// ****************************************
	a_i2c_skip: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
		start_ev && !i3c_mode |=> c_r.st == CEE_SKIP && !sda_oe)
		else $error("frame decoded outside i3c mode");
	a_dis_clears: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
		scl_rise && c_r.cnt == CEE_ACK_BIT && c_r.st == CEE_DATA && !pec_enable && !par_bad
		&& !c_r.err && c_r.sh[0] && c_r.code[0] |=> !irq_enable_pending)
		else $error("disable did not clear pending enable");
	a_en_sets: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
		scl_rise && c_r.cnt == CEE_ACK_BIT && c_r.st == CEE_DATA && !pec_enable && !par_bad
		&& !c_r.err && c_r.sh[0] && !c_r.code[0] |=> irq_enable_pending)
		else $error("enable did not set pending enable");
	a_apply_at_start: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
		$changed(inband_irq_enable_bit) |-> $past(start_ev) && $past(c_r.idle))
		else $error("enable bit moved outside a start after stop");
	a_crc_restart: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
		start_ev |=> c_r.crc == CEE_CRC_INIT ##1 c_r.crc == CEE_CRC_INIT)
		else $error("checksum not restarted");
	a_err_nacks: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
		start_ev && !c_r.idle && c_r.err |=> c_r.nack ##0 (!sda_oe throughout c_r.st == CEE_ADDR))
		else $error("address acknowledged after error");
	a_skip_quiet: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
		c_r.st == CEE_SKIP && !start_ev && !stop_ev |=> $stable(c_r.err) && !sda_oe)
		else $error("skipped packet was checked");
	a_pec_block: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
		scl_rise && c_r.cnt == CEE_ACK_BIT && c_r.st == CEE_PEC2 && pec_bad
		|=> $stable(irq_enable_pending) ##1 c_r.err)
		else $error("change applied despite checksum mismatch");
	a_stop_idle: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
		stop_ev |=> c_r.st == CEE_IDLE && c_r.idle && !sda_oe)
		else $error("stop not recognised");
endmodule

//--- test/cee_host.sv
/* host model of the serial bus: start, stop and byte tasks at bit level.
   assumes a pull-up on sda and the device pulling low through its enable. */
module cee_host(
	input wire logic clk,
	input wire logic dev_oe,
	input wire logic dev_out,
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drv;
	// pull-up wire: high unless either party pulls low
	assign sda = drv & ~(dev_oe & ~dev_out);
	initial begin
		scl = 1'b1;
		drv = 1'b1;
	end
	// quarter of a 160 ns link period
	task q;
		repeat (4) @(posedge clk);
	endtask
	task start;
		drv <= 1'b1; q; scl <= 1'b1; q; drv <= 1'b0; q; scl <= 1'b0; q;
	endtask
	task stop;
		drv <= 1'b0; q; scl <= 1'b1; q; drv <= 1'b1; q;
	endtask
	task wr(input logic [7:0] v, input logic ninth, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			drv <= v[i]; q; scl <= 1'b1; q; q; scl <= 1'b0; q;
		end
		drv <= ninth; q; scl <= 1'b1; q; ack = ~sda; q; scl <= 1'b0; q;
	endtask
endmodule

//--- test/tb_top.sv
/* self-checking bench for the event enable/disable decoder.
   assumes the host model drives the link; expectations come from the bench. */
module tb_top
	import cee_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic mode = 1'b1;
	logic pec = 1'b1;
	logic [6:0] own = 7'h00;
	logic [31:0] rv;
	logic exp_p, exp_a;
	wire logic scl, sda, sdo, oe, irq_bit, pend, ferr;
	int failures = 0;
	int checks = 0;
	always #5 clk = ~clk;
	cee_ccc_event_ctl dut_u(.clk(clk), .rst_n(rst_n), .scl_pin(scl), .sda_pin(sda),
		.sda_out(sdo), .sda_oe(oe), .i3c_mode(mode), .pec_enable(pec), .own_addr(own),
		.inband_irq_enable_bit(irq_bit), .irq_enable_pending(pend), .frame_error(ferr));
	cee_host h(.clk(clk), .dev_oe(oe), .dev_out(sdo), .scl(scl), .sda(sda));
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] x;
		x = c ^ b;
		repeat (8) x = x[7] ? ({x[6:0], 1'b0} ^ CEE_CRC_POLY) : {x[6:0], 1'b0};
		return x;
	endfunction
	task chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task frame(input logic dir, en, flag, match, perr, cerr, endsr);
		logic [7:0] c, a, d, r;
		logic ak, bad, ok;
		c = {dir, 6'h00, ~en};
		a = {match ? own : own ^ 7'h15, 1'b0};
		d = {7'h00, flag};
		bad = perr | (pec & cerr);
		ok = mode & (~dir | match) & ~bad & flag;
		h.start;
		// any start out of idle applies the pending value, whatever the mode
		chk(irq_bit, exp_p);
		exp_a = exp_p;
		h.wr(CEE_BCAST_W, 1'b1, ak);
		chk(ak, mode);
		// broadcast write byte stays out of the checksum
		r = crc8(CEE_CRC_INIT, c);
		h.wr(c, ~^c, ak);
		// only a direct command carries a checksum byte after its code
		if (pec & dir) h.wr(r, ~^r, ak);
		if (dir) begin
			h.start;
			h.wr(a, 1'b1, ak);
			chk(ak, mode & match);
			r = crc8(CEE_CRC_INIT, a);
		end
		h.wr(d, ~^d ^ perr, ak);
		r = crc8(r, d) ^ {7'h00, cerr};
		if (pec) h.wr(r, ~^r, ak);
		chk(ferr, mode & (~dir | match) & bad);
		if (ok) exp_p = en;
		if (endsr) begin
			h.start;
			h.wr(CEE_BCAST_W, 1'b1, ak);
			chk(ak, mode & ~(bad & (~dir | match)));
		end
		h.stop;
		repeat (8) @(posedge clk);
		chk(pend, exp_p);
		chk(irq_bit, exp_a);
	endtask
	task summarize;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		rv = $urandom(96140);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		// keep both our address and its mismatch copy off the broadcast address
		own <= (rv[6:0] == 7'h7e || rv[6:0] == 7'h6b) ? 7'h2a : rv[6:0];
		repeat (4) @(posedge clk);
		chk(irq_bit, CEE_IRQ_EN_RST);
		chk(pend, CEE_IRQ_EN_RST);
		exp_p = CEE_IRQ_EN_RST;
		exp_a = CEE_IRQ_EN_RST;
		frame(0, 1, 1, 1, 0, 0, 0);
		frame(1, 0, 1, 1, 1, 0, 1);
		frame(1, 0, 1, 0, 1, 0, 1);
		frame(0, 0, 1, 1, 0, 1, 1);
		frame(1, 1, 1, 1, 0, 0, 1);
		for (int i = 0; i < 40; i++) begin
			rv = $urandom;
			@(posedge clk);
			mode <= rv[16:14] != 3'h0;
			pec <= rv[17];
			@(posedge clk);
			frame(rv[0], rv[1], rv[4:2] != 3'h0, rv[6:5] != 2'h0, rv[9:7] == 3'h0,
				rv[12:10] == 3'h0, rv[13]);
		end
		summarize;
	end
	initial begin
		repeat (90000) @(posedge clk);
		failures++;
		summarize;
	end
endmodule
